// >>> hdl/traffic_storm_suppressor.sv
// Purpose: per-port storm suppression for broadcast, multicast and unicast
// Assumes: all inputs come from logic on MCLK; frames are given as descriptors
// Notes:   rates are measured on received frames, dropped ones included
`timescale 1ns/1ps
`include "tss_defs.svh"

module storm_fifo #(
  parameter int WIDTH = `TSS_DESC_W,
  parameter int DEPTH = `TSS_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;
  fifo_state_t      s;
  fifo_state_t      next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = !((s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]));
  assign out_valid = (s.wr != s.rd);
  assign out_data  = mem[s.rd[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage needs no reset; empty flag guards stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

module traffic_storm_suppressor import tss_pkg::*; #(
  parameter int SAMPLE_CYCLES = `TSS_SAMPLE_CYC
) (
  input  wire logic             MCLK,
  input  wire logic             RST_B,
  input  wire logic [1:0]       PORT_KIND,
  input  wire logic             ADMIN_UP,
  input  wire logic             ADMIN_DOWN,
  input  wire logic [1:0]       LINK_SPEED,
  input  wire logic             GROUP_MEMBER,
  input  wire logic [2:0]       SC_EN,
  input  wire logic [2:0][1:0]  SC_MODE,
  input  wire logic [2:0][39:0] SC_RISE,
  input  wire logic [2:0][39:0] SC_FALL,
  input  wire logic [2:0]       SC_FALL_SET,
  input  wire logic             ACT_TRAP,
  input  wire logic             ACT_SHUT,
  input  wire logic [2:0]       GRP_EN,
  input  wire logic [2:0][1:0]  GRP_MODE,
  input  wire logic [2:0][39:0] GRP_RISE,
  input  wire logic [2:0][39:0] GRP_FALL,
  input  wire logic [2:0]       GRP_FALL_SET,
  input  wire logic             GRP_ACT_TRAP,
  input  wire logic             GRP_ACT_SHUT,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [1:0]       IN_CLASS,
  input  wire logic             IN_CTRL,
  input  wire logic [15:0]      IN_LEN,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic [1:0]            OUT_CLASS,
  output logic                  OUT_CTRL,
  output logic [15:0]           OUT_LEN,
  output logic [2:0]            STORM_ACTIVE,
  output logic                  TRAP_EVENT,
  output logic                  PORT_ERR_DISABLED,
  output logic                  PORT_ENABLED
);
  logic                  rst_meta;
  logic                  rst_n;
  tss_state_t            s;
  tss_state_t            next_s;
  logic [2:0]            en;
  logic [2:0][1:0]       mode;
  logic [2:0][39:0]      rise;
  logic [2:0][39:0]      fall;
  logic [2:0]            fall_set;
  logic                  act_trap;
  logic                  act_shut;
  logic [2:0][39:0]      fall_eff;
  logic [2:0]            active;
  logic [2:0]            zero_lvl;
  logic [2:0]            hit_rise;
  logic [2:0]            below_fall;
  logic [2:0]            add_pkt;
  logic                  in_take;
  logic                  tick_end;
  logic                  storm;
  logic                  f_valid;
  logic                  f_pop;
  logic [18:0]           f_data;
  logic                  drop_head;
  logic                  out_free;

  function automatic logic [55:0] speed_tenths(input logic [1:0] spd);
    unique case (speed_t'(spd))
      SPD_10M:  speed_tenths = `TSS_SPD_10M;
      SPD_100M: speed_tenths = `TSS_SPD_100M;
      SPD_1G:   speed_tenths = `TSS_SPD_1G;
      SPD_10G:  speed_tenths = `TSS_SPD_10G;
    endcase
  endfunction

  function automatic logic [55:0] rate_of(input logic [1:0] m, input logic [23:0] b, input logic [23:0] p);
    logic [55:0] bits10;
    bits10 = 56'(b) * 56'(`TSS_BIT_SCALE);
    unique case (m)
      MODE_PCT: rate_of = bits10 * 56'(`TSS_PCT_FULL);
      MODE_BPS: rate_of = bits10;
      default:  rate_of = 56'(p) * 56'(`TSS_PKT_SCALE);
    endcase
  endfunction

  function automatic logic [55:0] thr_of(input logic [1:0] m, input logic [39:0] t, input logic [1:0] spd);
    if (m == MODE_PCT) begin
      thr_of = 56'(t) * speed_tenths(spd);
    end else begin
      thr_of = 56'(t);
    end
  endfunction

  function automatic logic blocked(input fwd_state_t [2:0] b, input logic [1:0] c, input logic ctrl);
    if (c == 2'h3) begin
      blocked = 1'b0;
    end else begin
      blocked = (b[c] == ST_BLOCK) && !((c == CLS_MCAST) && ctrl);
    end
  endfunction

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign en       = GROUP_MEMBER ? GRP_EN : SC_EN;
  assign mode     = GROUP_MEMBER ? GRP_MODE : SC_MODE;
  assign rise     = GROUP_MEMBER ? GRP_RISE : SC_RISE;
  assign fall     = GROUP_MEMBER ? GRP_FALL : SC_FALL;
  assign fall_set = GROUP_MEMBER ? GRP_FALL_SET : SC_FALL_SET;
  assign act_trap = GROUP_MEMBER ? GRP_ACT_TRAP : ACT_TRAP;
  assign act_shut = GROUP_MEMBER ? GRP_ACT_SHUT : ACT_SHUT;

  assign in_take  = IN_VALID && IN_READY;
  assign tick_end = (s.tick == 24'(SAMPLE_CYCLES - 1));

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_cls
      assign fall_eff[c]   = (fall_set[c] && (fall[c] <= rise[c])) ? fall[c] : rise[c];
      assign active[c]     = en[c] && s.admin_en && !((mode[c] == MODE_PCT) && (rise[c] >= `TSS_PCT_FULL));
      assign zero_lvl[c]   = (rise[c] == 40'h0) && (fall_eff[c] == 40'h0);
      assign hit_rise[c]   = rate_of(mode[c], s.bytes[c], s.pkts[c]) >= thr_of(mode[c], rise[c], LINK_SPEED);
      assign below_fall[c] = rate_of(mode[c], s.bytes[c], s.pkts[c]) < thr_of(mode[c], fall_eff[c], LINK_SPEED);
      assign add_pkt[c]    = in_take && (IN_CLASS == 2'(c));
      assign STORM_ACTIVE[c] = (s.blk[c] == ST_BLOCK);
    end
  endgenerate

  storm_fifo #(
    .WIDTH (`TSS_DESC_W),
    .DEPTH (`TSS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (rst_n),
    .in_valid  (IN_VALID),
    .in_ready  (IN_READY),
    .in_data   ({IN_CTRL, IN_CLASS, IN_LEN}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign drop_head = !s.admin_en || s.err_dis ||
                     blocked(s.blk, f_data[`TSS_D_CLS_HI:`TSS_D_CLS_LO], f_data[`TSS_D_CTRL]);
  assign out_free  = !s.out_valid || OUT_READY;
  assign f_pop     = f_valid && (drop_head || out_free);

  always_comb begin
    next_s = s;
    storm  = 1'b0;
    if (!s.started) begin
      next_s.started  = 1'b1;
      next_s.admin_en = (PORT_KIND == KIND_NET);
    end
    if (ADMIN_DOWN) begin
      next_s.admin_en = 1'b0;
    end
    if (ADMIN_UP) begin
      next_s.admin_en = 1'b1;
      next_s.err_dis  = 1'b0;
    end
    next_s.tick = tick_end ? 24'h0 : s.tick + 24'h1;
    for (int i = 0; i < 3; i++) begin
      if (tick_end) begin
        next_s.bytes[i] = add_pkt[i] ? 24'(IN_LEN) : 24'h0;
        next_s.pkts[i]  = add_pkt[i] ? 24'h1 : 24'h0;
      end else if (add_pkt[i]) begin
        // saturate so a long interval never wraps to a low rate
        next_s.bytes[i] = (s.bytes[i] > (24'hffffff - 24'(IN_LEN))) ? 24'hffffff : s.bytes[i] + 24'(IN_LEN);
        next_s.pkts[i]  = (s.pkts[i] == 24'hffffff) ? s.pkts[i] : s.pkts[i] + 24'h1;
      end
      unique case (s.blk[i])
        ST_PASS: begin
          if (active[i] && (zero_lvl[i] || (tick_end && hit_rise[i]))) begin
            next_s.blk[i] = ST_BLOCK;
            storm         = 1'b1;
          end
        end
        ST_BLOCK: begin
          if (!active[i] || (tick_end && below_fall[i] && !zero_lvl[i])) begin
            next_s.blk[i] = ST_PASS;
          end
        end
      endcase
    end
    if (storm && act_shut) begin
      next_s.err_dis = 1'b1;
    end
    next_s.trap = storm && act_trap;
    if (s.out_valid && OUT_READY) begin
      next_s.out_valid = 1'b0;
    end
    if (f_valid && !drop_head && out_free) begin
      next_s.out_valid = 1'b1;
      next_s.out_desc  = f_data;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign OUT_VALID         = s.out_valid;
  assign OUT_CTRL          = s.out_desc[`TSS_D_CTRL];
  assign OUT_CLASS         = s.out_desc[`TSS_D_CLS_HI:`TSS_D_CLS_LO];
  assign OUT_LEN           = s.out_desc[`TSS_D_LEN_HI:0];
  assign TRAP_EVENT        = s.trap;
  assign PORT_ERR_DISABLED = s.err_dis;
  assign PORT_ENABLED      = s.admin_en && !s.err_dis;
endmodule

// >>> hdl/tss_defs.svh
// Purpose: constants for the traffic storm suppressor
// Assumes: MCLK at 25 MHz
// Notes:   the sample count of 25000 cycles can be overridden by a top parameter
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
`define TSS_CLK_MHZ     25
`define TSS_SAMPLE_US   1000
`define TSS_SAMPLE_CYC  (`TSS_SAMPLE_US * `TSS_CLK_MHZ)
`define TSS_IPS         (1000000 / `TSS_SAMPLE_US)
`define TSS_BIT_SCALE   (8 * 10 * `TSS_IPS)
`define TSS_PKT_SCALE   (10 * `TSS_IPS)
`define TSS_PCT_FULL    40'h2710
`define TSS_SPD_10M     56'h5f5e100
`define TSS_SPD_100M    56'h3b9aca00
`define TSS_SPD_1G      56'h2540be400
`define TSS_SPD_10G     56'h174876e800
`define TSS_DESC_W      19
`define TSS_D_CTRL      18
`define TSS_D_CLS_HI    17
`define TSS_D_CLS_LO    16
`define TSS_D_LEN_HI    15
`define TSS_FIFO_DEPTH  8
`endif

// >>> hdl/tss_pkg.sv
// Purpose: types for the traffic storm suppressor
// Assumes: tss_defs.svh constants
// Notes:   class codes double as indices of the per-class config ports
package tss_pkg;
  typedef enum logic [1:0] {MODE_PCT = 2'h0, MODE_BPS = 2'h1, MODE_PPS = 2'h2} mode_t;
  typedef enum logic [1:0] {CLS_BCAST = 2'h0, CLS_MCAST = 2'h1, CLS_UCAST = 2'h2} class_t;
  typedef enum logic [1:0] {KIND_USER = 2'h0, KIND_ENH = 2'h1, KIND_NET = 2'h2} kind_t;
  typedef enum logic [1:0] {SPD_10M = 2'h0, SPD_100M = 2'h1, SPD_1G = 2'h2, SPD_10G = 2'h3} speed_t;
  typedef enum logic {ST_PASS = 1'b0, ST_BLOCK = 1'b1} fwd_state_t;
  typedef struct packed {
    fwd_state_t [2:0]       blk;
    logic [2:0][23:0]       bytes;
    logic [2:0][23:0]       pkts;
    logic [23:0]            tick;
    logic                   err_dis;
    logic                   admin_en;
    logic                   started;
    logic                   trap;
    logic                   out_valid;
    logic [18:0]            out_desc;
  } tss_state_t;
endpackage

// >>> test/fwd_sink.sv
// Purpose: forwarding path model taking frames
// Assumes: stall driven at rising edge
// Notes:   stall lets the bench fill the queue
`timescale 1ns/1ps
module fwd_sink (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic       valid,
  input  wire logic [1:0] cls,
  input  wire logic       ctrl,
  output logic            ready,
  output logic [15:0]     n,
  output logic [1:0]      last_cls,
  output logic            last_ctrl
);
  assign ready = !stall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n <= 16'h0;
      last_cls <= 2'h3;
      last_ctrl <= 1'b0;
    end else if (valid && ready) begin
      n <= n + 16'h1;
      last_cls <= cls;
      last_ctrl <= ctrl;
    end
  end
endmodule

// >>> test/tb.sv
// Purpose: self-checking bench for traffic_storm_suppressor
// Assumes: short sampling interval of 50 cycles
// Notes:   pkt/s levels in tenths, one frame per interval is 10000
`timescale 1ns/1ps
module tb;
  logic             MCLK = 1'b0, RST_B = 1'b0, ADMIN_UP = 1'b0, ADMIN_DOWN = 1'b0, GROUP_MEMBER = 1'b0;
  logic [1:0]       PORT_KIND = 2'h0, LINK_SPEED = 2'h2, IN_CLASS = 2'h0, OUT_CLASS;
  logic [2:0]       SC_EN = 3'h0, SC_FALL_SET = 3'h0, GRP_EN = 3'h0, GRP_FALL_SET = 3'h0, STORM_ACTIVE;
  logic [2:0][1:0]  SC_MODE = '0, GRP_MODE = '0;
  logic [2:0][39:0] SC_RISE = '0, SC_FALL = '0, GRP_RISE = '0, GRP_FALL = '0;
  logic             ACT_TRAP = 1'b0, ACT_SHUT = 1'b0, GRP_ACT_TRAP = 1'b0, GRP_ACT_SHUT = 1'b0;
  logic             IN_VALID = 1'b0, IN_CTRL = 1'b0, stall = 1'b0;
  logic             IN_READY, OUT_VALID, OUT_READY, OUT_CTRL, TRAP_EVENT, PORT_ERR_DISABLED, PORT_ENABLED;
  logic [15:0]      OUT_LEN, n, n0;
  logic [1:0]       last_cls;
  logic             last_ctrl;
  int               n_mismatch = 0, cmp_count = 0, trap_cnt = 0;
  always #20 MCLK = ~MCLK;
  always @(posedge MCLK) if (TRAP_EVENT === 1'b1) trap_cnt++;
  traffic_storm_suppressor #(.SAMPLE_CYCLES(50)) dut (.MCLK(MCLK), .RST_B(RST_B), .PORT_KIND(PORT_KIND),
    .ADMIN_UP(ADMIN_UP), .ADMIN_DOWN(ADMIN_DOWN), .LINK_SPEED(LINK_SPEED), .GROUP_MEMBER(GROUP_MEMBER),
    .SC_EN(SC_EN), .SC_MODE(SC_MODE), .SC_RISE(SC_RISE), .SC_FALL(SC_FALL), .SC_FALL_SET(SC_FALL_SET),
    .ACT_TRAP(ACT_TRAP), .ACT_SHUT(ACT_SHUT), .GRP_EN(GRP_EN), .GRP_MODE(GRP_MODE), .GRP_RISE(GRP_RISE),
    .GRP_FALL(GRP_FALL), .GRP_FALL_SET(GRP_FALL_SET), .GRP_ACT_TRAP(GRP_ACT_TRAP), .GRP_ACT_SHUT(GRP_ACT_SHUT),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_CLASS(IN_CLASS), .IN_CTRL(IN_CTRL), .IN_LEN(16'h0040),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_CLASS(OUT_CLASS), .OUT_CTRL(OUT_CTRL), .OUT_LEN(OUT_LEN),
    .STORM_ACTIVE(STORM_ACTIVE), .TRAP_EVENT(TRAP_EVENT), .PORT_ERR_DISABLED(PORT_ERR_DISABLED),
    .PORT_ENABLED(PORT_ENABLED));
  fwd_sink sink (.clk(MCLK), .rst_n(RST_B), .stall(stall), .valid(OUT_VALID), .cls(OUT_CLASS), .ctrl(OUT_CTRL),
    .ready(OUT_READY), .n(n), .last_cls(last_cls), .last_ctrl(last_ctrl));
  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge MCLK);
    #1;
  endtask
  // frames held valid back to back until cnt taken
  task burst(input logic [1:0] c, input logic k, input int cnt);
    int t, j;
    t = 0;
    @(posedge MCLK);
    IN_VALID <= 1'b1;
    IN_CLASS <= c;
    IN_CTRL <= k;
    for (j = 0; j < 300 && t < cnt; j++) begin
      @(posedge MCLK);
      if (IN_READY === 1'b1) t++;
    end
    IN_VALID <= 1'b0;
    if (t != cnt) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task wst(input int b, input logic v);
    int j;
    for (j = 0; j < 300 && STORM_ACTIVE[b] !== v; j++) wt(1);
    if (j == 300) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // one frame every 20 cycles: 2 or 3 per interval
  task pace(input logic [1:0] c, input int cnt);
    int k;
    for (k = 0; k < cnt; k++) begin
      burst(c, 1'b0, 1);
      wt(18);
    end
  endtask
  task up;
    @(posedge MCLK);
    ADMIN_UP <= 1'b1;
    @(posedge MCLK);
    ADMIN_UP <= 1'b0;
    wt(2);
  endtask
  initial begin
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    wt(4);
    chk(PORT_ENABLED, 1'b0); // user port starts down
    chk(STORM_ACTIVE, 3'h0); // all classes off
    burst(2'h2, 1'b0, 1);
    wt(5);
    chk(n, 16'h0); // dropped while down
    up();
    chk(PORT_ENABLED, 1'b1); // enabled by software
    @(posedge MCLK);
    stall <= 1'b1;
    burst(2'h2, 1'b0, 9);
    wt(2);
    chk(IN_READY, 1'b0); // queue full, classes off
    chk({OUT_VALID, OUT_CLASS, OUT_LEN}, {1'b1, 2'h2, 16'h0040}); // head frame stands while stalled
    @(posedge MCLK);
    stall <= 1'b0;
    wt(20);
    chk(n, 16'h9); // all frames forwarded
    @(posedge MCLK);
    SC_MODE[0] <= 2'h2;
    SC_RISE[0] <= 40'd30000;
    SC_FALL[0] <= 40'd10000;
    SC_FALL_SET[0] <= 1'b1;
    SC_EN <= 3'h1;
    ACT_TRAP <= 1'b1;
    burst(2'h0, 1'b0, 6);
    wst(0, 1'b1); // packet rate reached
    // trap counter and sink lag the storm edge by a cycle
    wt(3);
    chk(trap_cnt, 1); // one event per storm
    n0 = n;
    // 2 or 3 frames per interval stay above falling level
    pace(2'h0, 8);
    chk(STORM_ACTIVE, 3'h1); // held above falling level
    burst(2'h2, 1'b0, 1);
    wt(5);
    chk(n, n0 + 16'h1); // only broadcast dropped
    chk(trap_cnt, 1); // no repeat while storming
    wst(0, 1'b0); // released when quiet
    @(posedge MCLK);
    SC_EN <= 3'h2;
    ACT_TRAP <= 1'b0;
    wt(2);
    chk(STORM_ACTIVE, 3'h2); // zero levels block
    n0 = n;
    burst(2'h1, 1'b1, 1);
    burst(2'h1, 1'b0, 1);
    wt(5);
    chk(n, n0 + 16'h1); // only control frame passes
    chk(last_ctrl, 1'b1); // control frame kept
    chk(last_cls, 2'h1); // multicast class kept
    @(posedge MCLK);
    SC_EN <= 3'h4;
    SC_MODE[2] <= 2'h2;
    SC_RISE[2] <= 40'd30000;
    ACT_SHUT <= 1'b1;
    burst(2'h2, 1'b0, 6);
    wst(2, 1'b1);
    chk({PORT_ERR_DISABLED, PORT_ENABLED}, 2'h2); // error-disabled
    chk(trap_cnt, 1); // shutdown without trap
    @(posedge MCLK);
    SC_EN <= 3'h0;
    wt(200);
    chk(PORT_ERR_DISABLED, 1'b1); // stays until re-enabled
    up();
    chk({PORT_ERR_DISABLED, PORT_ENABLED}, 2'h1); // cleared by software
    @(posedge MCLK);
    GROUP_MEMBER <= 1'b1;
    GRP_EN <= 3'h1;
    wt(2);
    chk(STORM_ACTIVE, 3'h1); // group settings used
    @(posedge MCLK);
    GROUP_MEMBER <= 1'b0;
    wt(2);
    chk(STORM_ACTIVE, 3'h0); // classes off again
    // percent level of three 64-byte frames per interval at 10M
    @(posedge MCLK);
    ACT_SHUT <= 1'b0;
    SC_EN <= 3'h1;
    SC_MODE[0] <= 2'h0;
    SC_RISE[0] <= 40'd1536;
    SC_FALL_SET[0] <= 1'b0;
    burst(2'h0, 1'b0, 6);
    wt(110);
    chk(STORM_ACTIVE, 3'h0); // far below level at 1G
    @(posedge MCLK);
    LINK_SPEED <= 2'h0;
    burst(2'h0, 1'b0, 6);
    wst(0, 1'b1); // level reached at 10M
    wst(0, 1'b0); // released below rising level
    // a full interval of back-to-back frames is far above line rate
    @(posedge MCLK);
    SC_RISE[0] <= 40'd10000;
    burst(2'h0, 1'b0, 60);
    wt(5);
    chk(STORM_ACTIVE, 3'h0); // full scale never limits
    // bit rate of two frames, falling set above rising
    @(posedge MCLK);
    SC_MODE[0] <= 2'h1;
    SC_RISE[0] <= 40'd10240000;
    SC_FALL[0] <= 40'd20000000;
    SC_FALL_SET[0] <= 1'b1;
    burst(2'h0, 1'b0, 6);
    wst(0, 1'b1); // bit rate reached
    pace(2'h0, 8);
    chk(STORM_ACTIVE, 3'h1); // falling clamped to rising
    wst(0, 1'b0); // released when quiet
    // second reset as a network port
    @(posedge MCLK);
    PORT_KIND <= 2'h2;
    RST_B <= 1'b0;
    repeat (3) @(posedge MCLK);
    RST_B <= 1'b1;
    wt(4);
    chk({PORT_ENABLED, STORM_ACTIVE}, 4'h8); // network port starts enabled
    complete_run();
  end
endmodule

// >>> test/tss_props.sv
// Purpose: port checker for traffic_storm_suppressor
// Assumes: one clock domain, RST_B as disable
// Notes:   bound to every instance of the top
`timescale 1ns/1ps
module tss_props #(
  parameter int SAMPLE_CYCLES = 25000
) (
  input wire logic             MCLK,
  input wire logic             RST_B,
  input wire logic             GROUP_MEMBER,
  input wire logic [2:0]       SC_EN,
  input wire logic [2:0][1:0]  SC_MODE,
  input wire logic [2:0][39:0] SC_RISE,
  input wire logic [2:0][39:0] SC_FALL,
  input wire logic [2:0]       GRP_EN,
  input wire logic             ACT_TRAP,
  input wire logic             GRP_ACT_TRAP,
  input wire logic             ADMIN_UP,
  input wire logic             OUT_VALID,
  input wire logic             OUT_READY,
  input wire logic [1:0]       OUT_CLASS,
  input wire logic [15:0]      OUT_LEN,
  input wire logic [2:0]       STORM_ACTIVE,
  input wire logic             TRAP_EVENT,
  input wire logic             PORT_ERR_DISABLED,
  input wire logic             PORT_ENABLED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  a_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable({OUT_CLASS, OUT_LEN}))
    else $error("output dropped while stalled");
  a_trap_entry: assert property (TRAP_EVENT |-> (STORM_ACTIVE & ~$past(STORM_ACTIVE)) != 3'h0)
    else $error("trap without storm entry");
  a_no_trap: assert property (!ACT_TRAP && !GRP_ACT_TRAP |=> !TRAP_EVENT)
    else $error("trap with trap action off");
  a_err_off: assert property (PORT_ERR_DISABLED |-> !PORT_ENABLED)
    else $error("error-disabled port enabled");
  a_err_hold: assert property (PORT_ERR_DISABLED && !ADMIN_UP |=> PORT_ERR_DISABLED)
    else $error("error-disable left without re-enable");
  a_off_pass: assert property (SC_EN == 3'h0 && GRP_EN == 3'h0 |=> STORM_ACTIVE == 3'h0)
    else $error("blocking with all classes off");
  a_full_pct: assert property (!GROUP_MEMBER && SC_MODE[0] == 2'h0 && SC_RISE[0] >= 40'h2710 |=> !STORM_ACTIVE[0])
    else $error("limit at full percentage");
  a_zero_block: assert property (!GROUP_MEMBER && SC_EN[1] && PORT_ENABLED && SC_RISE[1] == 40'h0
    && SC_FALL[1] == 40'h0 |=> STORM_ACTIVE[1])
    else $error("zero levels not blocking");
  cover property ($rose(STORM_ACTIVE[0]));
  cover property (TRAP_EVENT);
  cover property ($rose(PORT_ERR_DISABLED));
endmodule
bind traffic_storm_suppressor tss_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_props (
  .MCLK(MCLK), .RST_B(RST_B), .GROUP_MEMBER(GROUP_MEMBER), .SC_EN(SC_EN), .SC_MODE(SC_MODE),
  .SC_RISE(SC_RISE), .SC_FALL(SC_FALL), .GRP_EN(GRP_EN), .ACT_TRAP(ACT_TRAP), .GRP_ACT_TRAP(GRP_ACT_TRAP),
  .ADMIN_UP(ADMIN_UP), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_CLASS(OUT_CLASS), .OUT_LEN(OUT_LEN),
  .STORM_ACTIVE(STORM_ACTIVE), .TRAP_EVENT(TRAP_EVENT), .PORT_ERR_DISABLED(PORT_ERR_DISABLED),
  .PORT_ENABLED(PORT_ENABLED));
